// file: src/fsc_map.svh
// Register offsets, field positions, reset values and codes of the bank
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// ------------------------------------------------------------------
// Bus geometry
// ------------------------------------------------------------------
`define FSC_ADDR_W          8
`define FSC_DATA_W          32

// ------------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------------
`define FSC_IDX_STRING_EN   6'h0c
`define FSC_IDX_SUPPLY      6'h0e
`define FSC_IDX_BOOST       6'h10
`define FSC_ADDR_STRING_EN  {`FSC_IDX_STRING_EN, 2'b00}
`define FSC_ADDR_SUPPLY     {`FSC_IDX_SUPPLY, 2'b00}
`define FSC_ADDR_BOOST      {`FSC_IDX_BOOST, 2'b00}
`define FSC_ADDR_SUPPLY_MSK 8'h48
`define FSC_ADDR_BOOST_MSK  8'h4c
`define FSC_ADDR_STRING_ST  8'h50
`define FSC_ADDR_PENDING    8'h54

// ------------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------------
`define FSC_PAIRS           8
`define FSC_FLAG_POS        16'haaaa
`define FSC_FLAGS_RST       8'h00
`define FSC_MASK_RST        16'haaaa
`define FSC_STRING_EN_RST   1'b1
`define FSC_EN_CMD_OFF      2'h1
`define FSC_EN_CMD_ON       2'h3
`define FSC_EN_RD_OFF       2'h0
`define FSC_EN_RD_ON        2'h2

`endif

// file: src/fsc_pkg.sv
// Types shared by the fault status and clear bank
package fsc_pkg;

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FSC_SEL_NONE      = 3'b000,
    FSC_SEL_STRING_EN = 3'b001,
    FSC_SEL_SUPPLY    = 3'b010,
    FSC_SEL_BOOST     = 3'b011,
    FSC_SEL_SUPPLY_MS = 3'b100,
    FSC_SEL_BOOST_MS  = 3'b101,
    FSC_SEL_STRING_ST = 3'b110,
    FSC_SEL_PENDING   = 3'b111
  } fsc_sel_t;

  // ----------------------------------------------------------------
  // Bus response codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSC_RESP_OKAY   = 2'b00,
    FSC_RESP_SLVERR = 2'b10
  } fsc_resp_t;

endpackage

// file: src/fsc_fault_pairs.sv
// Sticky fault flags with paired clear
`timescale 1ns/1ps
`include "fsc_map.svh"

module fsc_fault_pairs #(
  parameter int PAIRS = `FSC_PAIRS
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [PAIRS-1:0] fault_in,
  input  wire logic [PAIRS-1:0] clear_in,
  output logic      [PAIRS-1:0] flags
);

  logic [PAIRS-1:0] flags_reg;
  logic [PAIRS-1:0] flags_next;

  // ------------------------------------------------------------------
  // Set beats clear, flag holds after the condition goes
  // ------------------------------------------------------------------
  always_comb begin
    flags_next = (flags_reg & ~clear_in) | fault_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= PAIRS'(`FSC_FLAGS_RST);
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule // fsc_fault_pairs

// file: src/fsc_bank.sv
// AXI4-Lite fault status and clear bank with one interrupt output
`timescale 1ns/1ps
`include "fsc_map.svh"

// ------------------------------------------------------------------
// Contract
// - Enable reads 0h when off, 2h on
// - Write 1h disables, 3h enables
// - Enable in bits 1-0, resets enabled
// - Status and clear written together clear fault
// - Status bit reads 1 when fault recorded
// - Checksum fault at 15, clear at 14
// - Missing sync fault at 13, clear 12
// - Pump fault at 11, clear at 10
// - Pump capacitor missing at 9, clear 8
// - Input overcurrent at 7, clear 6
// - Logic low 5/4, input OV 3/2, UV 1/0
// - Thermal fault at 15, clear at 14
// - Pin faults at 13/12, 11/10, 9/8, 7/6
// - Converter OC 5/4, OV high 3/2, low 1/0
// ------------------------------------------------------------------

module fsc_bank
  import fsc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`FSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [`FSC_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`FSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [`FSC_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [7:0]            supply_fault_in,
  input  wire logic [7:0]            boost_fault_in,
  input  wire logic                  string_fault_in,
  output logic                       irq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic fsc_sel_t decode(input logic [`FSC_ADDR_W-1:0] a);
    logic [`FSC_ADDR_W-1:0] w;
    w = {a[`FSC_ADDR_W-1:2], 2'b00};
    case (w)
      `FSC_ADDR_STRING_EN:  decode = FSC_SEL_STRING_EN;
      `FSC_ADDR_SUPPLY:     decode = FSC_SEL_SUPPLY;
      `FSC_ADDR_BOOST:      decode = FSC_SEL_BOOST;
      `FSC_ADDR_SUPPLY_MSK: decode = FSC_SEL_SUPPLY_MS;
      `FSC_ADDR_BOOST_MSK:  decode = FSC_SEL_BOOST_MS;
      `FSC_ADDR_STRING_ST:  decode = FSC_SEL_STRING_ST;
      `FSC_ADDR_PENDING:    decode = FSC_SEL_PENDING;
      default:              decode = FSC_SEL_NONE;
    endcase
  endfunction

  // Flag i sits at bit 2i+1, its clear bit at 2i, clear reads zero
  function automatic logic [15:0] spread(input logic [7:0] f);
    logic [15:0] o;
    o = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      o[2*i+1] = f[i];
    end
    return o;
  endfunction

  // Both bits of a pair must be one in an enabled byte lane
  function automatic logic [7:0] pair_clears(
    input logic [`FSC_DATA_W-1:0] d,
    input logic [3:0]             s
  );
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c[i] = d[2*i+1] & d[2*i] & s[i/4];
    end
    return c;
  endfunction

  // Byte-lane merge limited to flag positions
  function automatic logic [15:0] merge_mask(
    input logic [15:0]            old,
    input logic [`FSC_DATA_W-1:0] d,
    input logic [3:0]             s
  );
    logic [15:0] m;
    m = old;
    if (s[0]) begin
      m[7:0] = d[7:0];
    end
    if (s[1]) begin
      m[15:8] = d[15:8];
    end
    return m & `FSC_FLAG_POS;
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic                   wr_fire;
  logic                   rd_fire;
  fsc_sel_t               wr_sel;
  fsc_sel_t               rd_sel;
  logic [7:0]             supply_flags;
  logic [7:0]             boost_flags;
  logic [7:0]             supply_clear;
  logic [7:0]             boost_clear;
  logic [15:0]            supply_word;
  logic [15:0]            boost_word;
  logic                   supply_pend;
  logic                   boost_pend;
  logic                   string_pend;

  logic                   string_en_reg;
  logic                   string_en_next;
  logic                   string_flag_reg;
  logic                   string_flag_next;
  logic [15:0]            supply_mask_reg;
  logic [15:0]            supply_mask_next;
  logic [15:0]            boost_mask_reg;
  logic [15:0]            boost_mask_next;

  logic                   bvalid_reg;
  logic                   bvalid_next;
  fsc_resp_t              bresp_reg;
  fsc_resp_t              bresp_next;
  logic                   rvalid_reg;
  logic                   rvalid_next;
  fsc_resp_t              rresp_reg;
  fsc_resp_t              rresp_next;
  logic [`FSC_DATA_W-1:0] rdata_reg;
  logic [`FSC_DATA_W-1:0] rdata_next;

  // ------------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------------
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = ~rvalid_reg;
  assign wr_sel        = decode(s_axi_awaddr);
  assign rd_sel        = decode(s_axi_araddr);

  // ------------------------------------------------------------------
  // Fault flag banks
  // ------------------------------------------------------------------
  always_comb begin
    supply_clear = 8'h00;
    boost_clear  = 8'h00;
    if (wr_fire && wr_sel == FSC_SEL_SUPPLY) begin
      supply_clear = pair_clears(s_axi_wdata, s_axi_wstrb);
    end
    if (wr_fire && wr_sel == FSC_SEL_BOOST) begin
      boost_clear = pair_clears(s_axi_wdata, s_axi_wstrb);
    end
  end

  fsc_fault_pairs #(
    .PAIRS    (`FSC_PAIRS)
  ) u_supply (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .fault_in (supply_fault_in),
    .clear_in (supply_clear),
    .flags    (supply_flags)
  );

  fsc_fault_pairs #(
    .PAIRS    (`FSC_PAIRS)
  ) u_boost (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .fault_in (boost_fault_in),
    .clear_in (boost_clear),
    .flags    (boost_flags)
  );

  // Supply index 7..0 lands on pairs 15/14 down to 1/0
  assign supply_word = spread(supply_flags);
  // Boost index 7..0 lands on pairs 15/14 down to 1/0
  assign boost_word  = spread(boost_flags);

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_comb begin
    string_en_next   = string_en_reg;
    string_flag_next = string_flag_reg;
    supply_mask_next = supply_mask_reg;
    boost_mask_next  = boost_mask_reg;
    if (wr_fire) begin
      case (wr_sel)
        FSC_SEL_STRING_EN: begin
          if (s_axi_wstrb[0]) begin
            if (s_axi_wdata[1:0] == `FSC_EN_CMD_OFF) begin
              string_en_next = 1'b0;
            end else if (s_axi_wdata[1:0] == `FSC_EN_CMD_ON) begin
              string_en_next = 1'b1;
            end
          end
        end
        FSC_SEL_SUPPLY_MS: begin
          supply_mask_next = merge_mask(supply_mask_reg, s_axi_wdata,
                                        s_axi_wstrb);
        end
        FSC_SEL_BOOST_MS: begin
          boost_mask_next = merge_mask(boost_mask_reg, s_axi_wdata,
                                       s_axi_wstrb);
        end
        FSC_SEL_STRING_ST: begin
          if (s_axi_wstrb[0] && s_axi_wdata[0]) begin
            string_flag_next = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Event wins over a clear in the same cycle
    if (string_fault_in) begin
      string_flag_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      string_en_reg   <= `FSC_STRING_EN_RST;
      string_flag_reg <= 1'b0;
      supply_mask_reg <= `FSC_MASK_RST;
      boost_mask_reg  <= `FSC_MASK_RST;
    end else begin
      string_en_reg   <= string_en_next;
      string_flag_reg <= string_flag_next;
      supply_mask_reg <= supply_mask_next;
      boost_mask_reg  <= boost_mask_next;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------------
  assign supply_pend = |(supply_word & supply_mask_reg);
  assign boost_pend  = |(boost_word & boost_mask_reg);
  assign string_pend = string_flag_reg & string_en_reg;
  assign irq         = supply_pend | boost_pend | string_pend;

  // ------------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------------
  always_comb begin
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next  = (wr_sel == FSC_SEL_NONE) ? FSC_RESP_SLVERR
                                             : FSC_RESP_OKAY;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = FSC_RESP_OKAY;
      rdata_next  = '0;
      case (rd_sel)
        FSC_SEL_STRING_EN: begin
          rdata_next[1:0] = string_en_reg ? `FSC_EN_RD_ON
                                          : `FSC_EN_RD_OFF;
        end
        FSC_SEL_SUPPLY: begin
          rdata_next[15:0] = supply_word;
        end
        FSC_SEL_BOOST: begin
          rdata_next[15:0] = boost_word;
        end
        FSC_SEL_SUPPLY_MS: begin
          rdata_next[15:0] = supply_mask_reg;
        end
        FSC_SEL_BOOST_MS: begin
          rdata_next[15:0] = boost_mask_reg;
        end
        FSC_SEL_STRING_ST: begin
          rdata_next[0] = string_flag_reg;
        end
        FSC_SEL_PENDING: begin
          rdata_next[2:0] = {string_pend, boost_pend, supply_pend};
        end
        default: begin
          rresp_next = FSC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= FSC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= FSC_RESP_OKAY;
      rdata_reg  <= '0;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

endmodule // fsc_bank

// file: verif/fsc_bank_assertions.sv
// Bus and fault bank checks bound to fsc_bank
`timescale 1ns/1ps
`include "fsc_map.svh"

module fsc_bank_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        string_fault_in,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // Shadow of the string enable
  // ----------------------------------------------------------------
  logic wr_go, rd_go, en_reg, en_next;
  assign wr_go = s_axi_awvalid && s_axi_awready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_comb begin
    en_next = en_reg;
    if (wr_go && s_axi_awaddr == `FSC_ADDR_STRING_EN && s_axi_wstrb[0]) begin
      if (s_axi_wdata[1:0] == `FSC_EN_CMD_OFF) en_next = 1'h0;
      if (s_axi_wdata[1:0] == `FSC_EN_CMD_ON) en_next = 1'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) en_reg <= `FSC_STRING_EN_RST;
    else en_reg <= en_next;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  en_read_a: assert property (
    rd_go && s_axi_araddr == `FSC_ADDR_STRING_EN
    |=> s_axi_rdata == {30'h0, $past(en_reg), 1'h0})
    else $error("string enable read wrong");
  clear_zero_a: assert property (
    rd_go && (s_axi_araddr == `FSC_ADDR_SUPPLY ||
              s_axi_araddr == `FSC_ADDR_BOOST)
    |=> (s_axi_rdata & 32'hffff5555) == 32'h0)
    else $error("clear or upper bits read nonzero");
  irq_hold_a: assert property (irq && !wr_go |=> irq)
    else $error("irq dropped without a write");
  string_irq_a: assert property (
    string_fault_in && en_reg && !wr_go |=> irq)
    else $error("enabled string fault gave no irq");
  bad_wr_a: assert property (wr_go && s_axi_awaddr > 8'h57
    |=> s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  bad_rd_a: assert property (rd_go && s_axi_araddr > 8'h57
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  cover property (wr_go && s_axi_awaddr == `FSC_ADDR_BOOST);
  cover property ($fell(irq));
  cover property (rd_go && s_axi_araddr > 8'h57);
endmodule // fsc_bank_assertions

bind fsc_bank fsc_bank_assertions fsc_bank_assertions_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .string_fault_in, .irq
);

// file: verif/fsc_bank_bench.sv
// Self-checking bench for the fault status and clear bank
`timescale 1ns/1ps
`include "fsc_map.svh"

module fsc_bank_bench;
  logic        aclk, aresetn, irq, string_fault_in;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, supply_fault_in, boost_fault_in;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [31:0] cyc = 32'h0;
  logic [39:0] rows [16];
  logic [3:0]  en_tab [4] = '{4'h4, 4'h8, 4'he, 4'h2};
  int          fail_count, n_tests;

  fsc_bank fsc_bank_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .supply_fault_in, .boost_fault_in, .string_fault_in, .irq
  );

  always #20 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = 2'h0,
                    input logic [3:0] st = 4'hf);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do @(negedge aclk); while (s_axi_awready !== 1'h1);
    @(posedge aclk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid  <= 1'h0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    chk("bresp", 32'(e), 32'(s_axi_bresp));
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  task automatic ci(input logic e);
    @(negedge aclk);
    chk("irq", 32'(e), 32'(irq));
  endtask

  // One-cycle detector pulse: {string, boost, supply}
  task automatic pulse(input logic [16:0] m);
    @(posedge aclk);
    {string_fault_in, boost_fault_in, supply_fault_in} <= m;
    @(posedge aclk);
    {string_fault_in, boost_fault_in, supply_fault_in} <= 17'h0;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h2000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  a;
    logic [31:0] s;
    aclk = 1'h0;
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h0;
    s_axi_wstrb = 4'hf;
    {string_fault_in, boost_fault_in, supply_fault_in} = 17'h0;
    // Row: address, detector input, flag word expected
    for (int i = 0; i < 16; i++) begin
      rows[i] = {(i < 8) ? `FSC_ADDR_SUPPLY : `FSC_ADDR_BOOST,
                 16'(1 << i), 16'(2 << (2 * (i % 8)))};
    end
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;

    rd(`FSC_ADDR_STRING_EN, 32'h2);
    rd(`FSC_ADDR_SUPPLY, 32'h0);
    rd(`FSC_ADDR_BOOST, 32'h0);
    rd(`FSC_ADDR_SUPPLY_MSK, 32'haaaa);
    rd(`FSC_ADDR_BOOST_MSK, 32'haaaa);
    rd(`FSC_ADDR_PENDING, 32'h0);
    ci(1'h0);
    $display("reset values test done");

    for (int i = 0; i < 16; i++) begin
      a = rows[i][39:32];
      s = {16'h0, rows[i][15:0]};
      pulse({1'h0, rows[i][31:16]});
      rd(a, s);
      ci(1'h1);
      wr(a, s);
      wr(a, s >> 1);
      rd(a, s);
      ci(1'h1);
      wr(a, s | (s >> 1));
      rd(a, 32'h0);
      ci(1'h0);
    end
    $display("fault pair table test done");

    pulse(17'h10000);
    ci(1'h1);
    foreach (en_tab[k]) begin
      wr(`FSC_ADDR_STRING_EN, 32'(en_tab[k][3:2]));
      rd(`FSC_ADDR_STRING_EN, 32'(en_tab[k][1:0]));
      ci(en_tab[k][1]);
    end
    rd(`FSC_ADDR_STRING_ST, 32'h1);
    wr(`FSC_ADDR_STRING_ST, 32'h1);
    rd(`FSC_ADDR_STRING_ST, 32'h0);
    ci(1'h0);
    $display("string enable test done");

    wr(`FSC_ADDR_SUPPLY_MSK, 32'h0);
    pulse(17'h80);
    ci(1'h0);
    rd(`FSC_ADDR_SUPPLY, 32'h8000);
    wr(`FSC_ADDR_SUPPLY_MSK, 32'haaaa);
    ci(1'h1);
    wr(8'h80, 32'hffff, 2'h2);
    rd(8'h80, 32'h0, 2'h2);
    ci(1'h1);
    rd(`FSC_ADDR_PENDING, 32'h1);
    wr(`FSC_ADDR_BOOST_MSK, 32'hffff);
    rd(`FSC_ADDR_BOOST_MSK, 32'haaaa);
    // Pair clear needs the byte lane that holds the pair
    pulse(17'h10);
    wr(`FSC_ADDR_SUPPLY, 32'h300, 2'h0, 4'h1);
    rd(`FSC_ADDR_SUPPLY, 32'h8200);
    wr(`FSC_ADDR_SUPPLY, 32'h300, 2'h0, 4'h2);
    rd(`FSC_ADDR_SUPPLY, 32'h8000);
    // Detector still high during the clear keeps the flag
    @(posedge aclk);
    boost_fault_in <= 8'h01;
    wr(`FSC_ADDR_BOOST, 32'h3);
    rd(`FSC_ADDR_BOOST, 32'h2);
    boost_fault_in <= 8'h00;
    wr(`FSC_ADDR_BOOST, 32'h3);
    rd(`FSC_ADDR_BOOST, 32'h0);
    ci(1'h1);
    $display("mask and unmapped test done");

    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`FSC_ADDR_SUPPLY, 32'h0);
    rd(`FSC_ADDR_STRING_EN, 32'h2);
    ci(1'h0);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule // fsc_bank_bench
